// *** hw/swg_top.sv ***
// swg_top: sinusoid generator with avalon-mm registers, dac sample output
// and the decimation strobe that paces the transform input
// assumes CLK_SYS_I is the analog clock and all inputs are synchronous
`timescale 1ns/100ps
`default_nettype none
`include "swg_map.svh"

// Functional notes
// - a 24-bit frequency word is held and bits 31:24 of its register are reserved.
// - output frequency is clock rate times frequency word over two to the 30.
// - with sinc3 bypassed the transform rate is converter rate (1.6 MHz or 800 kHz) over the sinc2 ratio.
// - in general the transform rate is converter rate over sinc3 ratio over sinc2 ratio.
// - a 20-bit phase offset, degrees over 360 times two to the 20, shifts the sinusoid.
// - only in sinusoid mode a 12-bit offset is added to every output sample.
// - the output offset is a signed twos complement number.
// - sinusoid samples are scaled by an 11-bit unsigned gain register.
module swg_top #(
    parameter int FCW_W = 24,
    parameter int PHASE_W = 20,
    parameter int DAC_W = 12,
    parameter int GAIN_W = 11
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // avalon-mm slave
    input wire logic [15:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // dac sample stream
    output logic [DAC_W-1:0] DAC_DATA_O,
    output logic DAC_VALID_O,
    // converter sample strobe in, transform input strobe out
    input wire logic ADC_SAMPLE_STB_I,
    output logic DFT_IN_STB_O
);

    if (FCW_W != 24 || PHASE_W != 20 || DAC_W != 12 || GAIN_W != 11 ||
        PHASE_W > `SWG_ACC_W) begin : g_chk
        $error("swg_top: widths differ from the generator datapath");
    end

    // byte-enable merge of a write into a register image
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // decimation step: returns true when the counter wraps at the ratio
    function automatic logic dec_hit(input logic [7:0] cnt,
            input logic [7:0] ratio);
        return (ratio <= 8'h01) || (cnt >= ratio - 8'h01);
    endfunction

    swg_pkg::swg_bus_req_t req;
    logic ack_r;
    logic take;
    logic [31:0] rdata_nxt;
    logic [FCW_W-1:0] freq_word_r;
    logic [PHASE_W-1:0] phase_or_level_shift_r;
    logic [DAC_W-1:0] out_offset_r;
    logic [GAIN_W-1:0] sine_gain_r;
    logic generator_enable_bit_r;
    swg_pkg::swg_wave_t waveform_type_select_r;
    swg_pkg::swg_filt_cfg_t filt_r;
    logic [`SWG_ACC_W-1:0] acc_r;
    logic [PHASE_W-1:0] lut_phase;
    logic signed [DAC_W-1:0] sine_s;
    logic signed [2*DAC_W-1:0] scaled;
    logic signed [DAC_W+1:0] level;
    logic [DAC_W-1:0] dac_nxt;
    logic running;
    logic half_r;
    logic [7:0] s3_cnt_r;
    logic [7:0] s2_cnt_r;
    logic stb_adc;
    logic stb_s3;

    assign req = '{rd: AVS_READ_I, wr: AVS_WRITE_I, addr: AVS_ADDRESS_I,
                   be: AVS_BYTEENABLE_I, wdata: AVS_WRITEDATA_I};

    // one wait cycle per access; the access completes on the ack edge
    assign take = (req.rd | req.wr) & ~ack_r;
    assign AVS_WAITREQUEST_O = (req.rd | req.wr) & ~ack_r;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    // read mux; reserved bits and unmapped offsets read zero
    always_comb begin
        rdata_nxt = '0;
        case (req.addr)
            `SWG_OFS_FREQ_WORD: rdata_nxt[FCW_W-1:0] = freq_word_r;
            `SWG_OFS_PHASE_OFS: rdata_nxt[PHASE_W-1:0] = phase_or_level_shift_r;
            `SWG_OFS_OUT_OFS: rdata_nxt[DAC_W-1:0] = out_offset_r;
            `SWG_OFS_GAIN: rdata_nxt[GAIN_W-1:0] = sine_gain_r;
            `SWG_OFS_GEN_CTRL: begin
                rdata_nxt[`SWG_CTRL_EN_BIT] = generator_enable_bit_r;
                rdata_nxt[`SWG_CTRL_TYPE_MSB:`SWG_CTRL_TYPE_LSB] =
                    waveform_type_select_r;
            end
            `SWG_OFS_FILT_CTRL: begin
                rdata_nxt[`SWG_FILT_RATE_BIT] = filt_r.rate_half;
                rdata_nxt[`SWG_FILT_BYP_BIT] = filt_r.s3_bypass;
                rdata_nxt[`SWG_FILT_S3_MSB:`SWG_FILT_S3_LSB] = filt_r.s3_ratio;
                rdata_nxt[`SWG_FILT_S2_MSB:`SWG_FILT_S2_LSB] = filt_r.s2_ratio;
            end
            `SWG_OFS_STATUS: begin
                rdata_nxt[`SWG_STAT_SAMPLE_MSB:0] = DAC_DATA_O;
                rdata_nxt[`SWG_STAT_RUN_BIT] = running;
            end
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            AVS_READDATA_O <= '0;
        end else if (take && req.rd) begin
            AVS_READDATA_O <= rdata_nxt;
        end
    end

    // register writes take effect on the edge where waitrequest is low
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            freq_word_r <= `SWG_RST_FREQ_WORD;
            phase_or_level_shift_r <= `SWG_RST_PHASE_OFS;
            out_offset_r <= `SWG_RST_OUT_OFS;
            sine_gain_r <= `SWG_RST_GAIN;
        end else if (req.wr && ack_r) begin
            case (req.addr)
                `SWG_OFS_FREQ_WORD: freq_word_r <= FCW_W'(merge_be(
                    32'(freq_word_r), req.wdata, req.be));
                `SWG_OFS_PHASE_OFS: phase_or_level_shift_r <= PHASE_W'(
                    merge_be(32'(phase_or_level_shift_r), req.wdata,
                    req.be));
                `SWG_OFS_OUT_OFS: out_offset_r <= DAC_W'(merge_be(
                    32'(out_offset_r), req.wdata, req.be));
                `SWG_OFS_GAIN: sine_gain_r <= GAIN_W'(merge_be(
                    32'(sine_gain_r), req.wdata, req.be));
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            generator_enable_bit_r <= 1'b0;
            waveform_type_select_r <= swg_pkg::SWG_WAVE_DC;
        end else if (req.wr && ack_r && req.addr == `SWG_OFS_GEN_CTRL &&
                     req.be[0]) begin
            generator_enable_bit_r <= req.wdata[`SWG_CTRL_EN_BIT];
            waveform_type_select_r <= swg_pkg::swg_wave_t'(
                req.wdata[`SWG_CTRL_TYPE_MSB:`SWG_CTRL_TYPE_LSB]);
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            filt_r <= '{rate_half: 1'b0, s3_bypass: 1'b0,
                        s3_ratio: `SWG_RST_FILT_RATIO,
                        s2_ratio: `SWG_RST_FILT_RATIO};
        end else if (req.wr && ack_r && req.addr == `SWG_OFS_FILT_CTRL) begin
            if (req.be[0]) begin
                filt_r.rate_half <= req.wdata[`SWG_FILT_RATE_BIT];
                filt_r.s3_bypass <= req.wdata[`SWG_FILT_BYP_BIT];
            end
            if (req.be[1]) begin
                filt_r.s3_ratio <= req.wdata[`SWG_FILT_S3_MSB:`SWG_FILT_S3_LSB];
            end
            if (req.be[2]) begin
                filt_r.s2_ratio <= req.wdata[`SWG_FILT_S2_MSB:`SWG_FILT_S2_LSB];
            end
        end
    end

    assign running = generator_enable_bit_r &&
                     waveform_type_select_r == swg_pkg::SWG_WAVE_SINE;

    // phase accumulator, wraps modulo two to the 30; held at zero when idle
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            acc_r <= '0;
        end else if (running) begin
            acc_r <= acc_r + `SWG_ACC_W'(freq_word_r);
        end else begin
            acc_r <= '0;
        end
    end

    assign lut_phase = acc_r[`SWG_ACC_W-1 -: PHASE_W] +
                       phase_or_level_shift_r;

    swg_sine_shaper #(
        .PHASE_W(PHASE_W),
        .OUT_W(DAC_W)
    ) u_shaper (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .phase_i(lut_phase),
        .sample_o(sine_s)
    );

    // gain, then signed offset, saturated to the dac range
    always_comb begin
        scaled = sine_s * $signed({1'b0, sine_gain_r});
        level = (DAC_W+2)'(scaled >>> `SWG_GAIN_FRAC) +
                (DAC_W+2)'($signed(out_offset_r));
        if (level > $signed((DAC_W+2)'({1'b0, {(DAC_W-1){1'b1}}}))) begin
            dac_nxt = {1'b0, {(DAC_W-1){1'b1}}};
        end else if (level < -$signed((DAC_W+2)'({1'b1, {(DAC_W-1){1'b0}}})))
        begin
            dac_nxt = {1'b1, {(DAC_W-1){1'b0}}};
        end else begin
            dac_nxt = level[DAC_W-1:0];
        end
    end

    // offset only applies in sinusoid mode; otherwise mid-scale zero
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DAC_DATA_O <= '0;
            DAC_VALID_O <= 1'b0;
        end else begin
            DAC_DATA_O <= running ? dac_nxt : '0;
            DAC_VALID_O <= running;
        end
    end

    // transform pacing: converter rate, optional halving, sinc3, sinc2
    assign stb_adc = ADC_SAMPLE_STB_I && (!filt_r.rate_half || half_r);
    assign stb_s3 = stb_adc && (filt_r.s3_bypass ||
                    dec_hit(s3_cnt_r, filt_r.s3_ratio));

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            half_r <= 1'b0;
            s3_cnt_r <= '0;
            s2_cnt_r <= '0;
            DFT_IN_STB_O <= 1'b0;
        end else begin
            if (ADC_SAMPLE_STB_I) begin
                half_r <= ~half_r;
            end
            if (stb_adc) begin
                s3_cnt_r <= stb_s3 ? 8'h00 : s3_cnt_r + 8'h01;
            end
            if (stb_s3) begin
                s2_cnt_r <= dec_hit(s2_cnt_r, filt_r.s2_ratio) ? 8'h00 :
                            s2_cnt_r + 8'h01;
            end
            DFT_IN_STB_O <= stb_s3 &&
                            dec_hit(s2_cnt_r, filt_r.s2_ratio);
        end
    end

endmodule // swg_top

`default_nettype wire

// *** hw/swg_map.svh ***
// swg_map.svh: register offsets, field positions and reset values of the
// sinusoid waveform generator; definitions only, included by bare name
`ifndef SWG_MAP_SVH
`define SWG_MAP_SVH

// register byte offsets on the avalon slave
`define SWG_OFS_FREQ_WORD 16'h2030
`define SWG_OFS_PHASE_OFS 16'h2034
`define SWG_OFS_OUT_OFS 16'h2038
`define SWG_OFS_GAIN 16'h203c
`define SWG_OFS_GEN_CTRL 16'h2040
`define SWG_OFS_FILT_CTRL 16'h2044
`define SWG_OFS_STATUS 16'h2048

// reset values
`define SWG_RST_FREQ_WORD 24'h000000
`define SWG_RST_PHASE_OFS 20'h00000
`define SWG_RST_OUT_OFS 12'h000
`define SWG_RST_GAIN 11'h000
`define SWG_RST_FILT_RATIO 8'h00

// generator control fields
`define SWG_CTRL_EN_BIT 0
`define SWG_CTRL_TYPE_LSB 1
`define SWG_CTRL_TYPE_MSB 2

// filter control fields
`define SWG_FILT_RATE_BIT 0
`define SWG_FILT_BYP_BIT 1
`define SWG_FILT_S3_LSB 8
`define SWG_FILT_S3_MSB 15
`define SWG_FILT_S2_LSB 16
`define SWG_FILT_S2_MSB 23

// status fields
`define SWG_STAT_SAMPLE_MSB 11
`define SWG_STAT_RUN_BIT 16

// phase accumulator width and fraction bits of the gain
`define SWG_ACC_W 30
`define SWG_GAIN_FRAC 11

`endif

// *** hw/swg_pkg.sv ***
// swg_pkg: types shared by the sinusoid waveform generator files
// assumes swg_map.svh constants for the field widths
package swg_pkg;

    // waveform type select codes
    typedef enum logic [1:0] {
        SWG_WAVE_DC = 2'b00,
        SWG_WAVE_RSVD = 2'b01,
        SWG_WAVE_SINE = 2'b10,
        SWG_WAVE_TRAP = 2'b11
    } swg_wave_t;

    // one avalon request as seen by the slave
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } swg_bus_req_t;

    // filter decimation settings
    typedef struct packed {
        logic rate_half;
        logic s3_bypass;
        logic [7:0] s3_ratio;
        logic [7:0] s2_ratio;
    } swg_filt_cfg_t;

endpackage

// *** hw/swg_sine_shaper.sv ***
// swg_sine_shaper: turns a phase word into a signed sine sample
// assumes phase is a binary fraction of one turn, msb is half a turn
`timescale 1ns/100ps
`default_nettype none

module swg_sine_shaper #(
    parameter int PHASE_W = 20,
    parameter int OUT_W = 12
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // phase in, sample out
    input wire logic [PHASE_W-1:0] phase_i,
    output logic signed [OUT_W-1:0] sample_o
);

    localparam int X_W = OUT_W - 1;
    localparam logic [X_W:0] HALF_SPAN = {1'b1, {X_W{1'b0}}};
    localparam logic [X_W-1:0] PEAK = {X_W{1'b1}};

    if (PHASE_W < OUT_W) begin : g_chk
        $error("swg_sine_shaper: phase narrower than output");
    end

    logic [X_W-1:0] x;
    logic [2*X_W+1:0] prod;
    logic [X_W+1:0] mag;
    logic [X_W-1:0] mag_sat;

    // parabolic half wave 4x(1-x), mirrored negative for the second half
    always_comb begin
        x = phase_i[PHASE_W-2 -: X_W];
        prod = {1'b0, x} * (HALF_SPAN - {1'b0, x});
        mag = prod[2*X_W-1 -: X_W+2];
        mag_sat = (mag > {2'b00, PEAK}) ? PEAK : mag[X_W-1:0];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sample_o <= '0;
        end else if (phase_i[PHASE_W-1]) begin
            sample_o <= -$signed({1'b0, mag_sat});
        end else begin
            sample_o <= $signed({1'b0, mag_sat});
        end
    end

endmodule // swg_sine_shaper

`default_nettype wire

// *** test/swg_top_sva.sv ***
// swg_top_sva: concurrent checks on the swg_top ports, bound to swg_top
// assumes one clock domain with RST_N_I as its asynchronous reset
`timescale 1ns/100ps
`default_nettype none
`include "swg_map.svh"
module swg_top_sva #(
    parameter int DAC_W = 12
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // avalon-mm slave
    input wire logic [15:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    // streams
    input wire logic [DAC_W-1:0] DAC_DATA_O,
    input wire logic DAC_VALID_O,
    input wire logic ADC_SAMPLE_STB_I,
    input wire logic DFT_IN_STB_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_req; AVS_READ_I || AVS_WRITE_I; endsequence
    sequence s_rd; AVS_READ_I && AVS_WAITREQUEST_O; endsequence
    property p_one_wait; s_req ##0 AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
    property p_idle; !(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O; endproperty
    a_idle: assert property (p_idle) else $error("wait without request");
    property p_first; $rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O; endproperty
    a_first: assert property (p_first) else $error("no first wait cycle");
    property p_unmap; s_rd ##0 (AVS_ADDRESS_I > `SWG_OFS_STATUS ||
        AVS_ADDRESS_I < `SWG_OFS_FREQ_WORD) |=> AVS_READDATA_O == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
    property p_fw; s_rd ##0 AVS_ADDRESS_I == `SWG_OFS_FREQ_WORD
        |=> AVS_READDATA_O[31:24] == 8'h00; endproperty
    a_fw: assert property (p_fw) else $error("freq reserved bits");
    property p_ph; s_rd ##0 AVS_ADDRESS_I == `SWG_OFS_PHASE_OFS
        |=> AVS_READDATA_O[31:20] == 12'h000; endproperty
    a_ph: assert property (p_ph) else $error("phase reserved bits");
    property p_of; s_rd ##0 AVS_ADDRESS_I == `SWG_OFS_OUT_OFS
        |=> AVS_READDATA_O[31:12] == 20'h00000; endproperty
    a_of: assert property (p_of) else $error("offset reserved bits");
    property p_dac_idle; !DAC_VALID_O [*2] |-> DAC_DATA_O == '0; endproperty
    a_dac_idle: assert property (p_dac_idle) else $error("idle dac not 0");
    property p_dft; DFT_IN_STB_O |-> $past(ADC_SAMPLE_STB_I); endproperty
    a_dft: assert property (p_dft) else $error("transform strobe uncaused");
endmodule // swg_top_sva
bind swg_top swg_top_sva #(.DAC_W(DAC_W)) u_swg_top_sva (
    .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .DAC_DATA_O(DAC_DATA_O), .DAC_VALID_O(DAC_VALID_O),
    .ADC_SAMPLE_STB_I(ADC_SAMPLE_STB_I), .DFT_IN_STB_O(DFT_IN_STB_O));
`default_nettype wire

// *** test/swg_dac_model.sv ***
// swg_dac_model: converter on the far side of the sample stream
// assumes samples are taken on the rising edge while valid is high
`timescale 1ns/100ps
`default_nettype none
module swg_dac_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // sample stream
    input wire logic valid_i,
    // samples converted since reset
    output logic [31:0] count_o
);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o <= 32'h0;
        end else if (valid_i) begin
            count_o <= count_o + 32'h1;
        end
    end
endmodule // swg_dac_model
`default_nettype wire

// *** test/tb_top.sv ***
// tb_top: self-checking bench for swg_top with a converter model
// assumes the design, the checker and the model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "swg_map.svh"
module tb_top;
    typedef struct {logic [31:0] fw, ph, gn, of; int k; logic [11:0] ex;} swg_row_t;
    swg_row_t rows [9] = '{
        '{0, 32'h40000, 32'h7ff, 0, 0, 12'h7fe}, '{0, 0, 0, 32'h800, 0, 12'h800},
        '{0, 0, 0, 32'h123, 0, 12'h123}, '{32'h400000, 0, 32'h7ff, 0, 64, 12'h7fe},
        '{32'h400000, 0, 32'h7ff, 0, 192, 12'h801},
        '{32'h400000, 32'h40000, 32'h7ff, 0, 128, 12'h801},
        '{0, 32'h40000, 32'h7ff, 32'h7ff, 0, 12'h7ff},
        '{0, 32'hc0000, 32'h7ff, 32'h800, 0, 12'h800},
        '{0, 32'h40000, 32'h400, 0, 0, 12'h3ff}};
    logic [15:0] rmap [3] = '{`SWG_OFS_FREQ_WORD, `SWG_OFS_PHASE_OFS, `SWG_OFS_OUT_OFS};
    logic [31:0] rmask [3] = '{32'h00ffffff, 32'h000fffff, 32'h00000fff};
    logic [31:0] fctl [4] = '{32'h20200, 32'h10201, 32'h10302, 32'h00300};
    int fn [4] = '{8, 8, 6, 9};
    int fex [4] = '{2, 2, 6, 3};
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, wreq, dac_v, adc = 0, dft;
    logic [15:0] addr = 0;
    logic [31:0] wdat = 0, rdata, r, dcnt;
    logic [11:0] dac_d;
    int error_cnt = 0, tests_run = 0, dft_cnt = 0;
    swg_top u_swg_top (.CLK_SYS_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hf),
        .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
        .DAC_DATA_O(dac_d), .DAC_VALID_O(dac_v), .ADC_SAMPLE_STB_I(adc),
        .DFT_IN_STB_O(dft));
    swg_dac_model u_swg_dac_model (.clk_i(clk), .rst_n_i(rst_n), .valid_i(dac_v),
        .count_o(dcnt));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(negedge clk) if (dft === 1'b1) dft_cnt++;
    task automatic report_and_stop();
        $display("errors %0d, checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] ex);
        tests_run++;
        if (got !== ex) begin
            error_cnt++;
            $display("mismatch at %0t: value %h, expected %h", $time, got, ex);
        end
    endtask
    task automatic chk_smp(input logic [11:0] got, input logic [11:0] ex);
        tests_run++;
        if (got !== ex) begin
            error_cnt++;
            $display("mismatch at %0t: sample %h, expected %h", $time, got, ex);
        end
    endtask
    task automatic hang();
        error_cnt++;
        $display("mismatch at %0t: wait timed out", $time);
        report_and_stop();
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
    endtask
    // one avalon access: held until the rising edge that sees waitrequest low;
    // read data is taken and the request released at that same edge
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdata;
        wr <= 0;
        rd <= 0;
        if (wreq !== 1'b0) hang();
    endtask
    task automatic wait_valid();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (dac_v !== 1'b1 && n < 50);
        if (dac_v !== 1'b1) hang();
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        hang();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        foreach (rows[i]) begin
            bus(1, `SWG_OFS_FREQ_WORD, rows[i].fw, r);
            bus(1, `SWG_OFS_PHASE_OFS, rows[i].ph, r);
            bus(1, `SWG_OFS_GAIN, rows[i].gn, r);
            bus(1, `SWG_OFS_OUT_OFS, rows[i].of, r);
            bus(1, `SWG_OFS_GEN_CTRL, 32'h5, r);
            wait_valid();
            repeat (rows[i].k) @(negedge clk);
            chk_smp(dac_d, rows[i].ex);
            bus(1, `SWG_OFS_GEN_CTRL, 32'h0, r);
        end
        do_reset();
        foreach (rmap[i]) begin
            bus(0, rmap[i], 0, r);
            chk_reg(r, 32'h0);
            bus(1, rmap[i], 32'hffffffff, r);
            bus(0, rmap[i], 0, r);
            chk_reg(r, rmask[i]);
        end
        bus(1, 16'h3000, 32'hffffffff, r);
        bus(0, 16'h3000, 0, r);
        chk_reg(r, 32'h0);
        // dc type with enable set must not run the sinusoid path
        bus(1, `SWG_OFS_GEN_CTRL, 32'h1, r);
        repeat (8) @(negedge clk);
        chk_reg(dcnt, 32'h0);
        foreach (fctl[i]) begin
            do_reset();
            bus(1, `SWG_OFS_FILT_CTRL, fctl[i], r);
            dft_cnt = 0;
            for (int j = 0; j < fn[i]; j++) begin
                @(posedge clk) adc <= 1;
                @(posedge clk) adc <= 0;
                @(posedge clk);
            end
            repeat (3) @(posedge clk);
            chk_reg(32'(dft_cnt), 32'(fex[i]));
        end
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
